// ===== src/bcd_reading_output_port.sv
// bcd reading output port with strobe, request, hold and axi4-lite registers
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps

module bcd_reading_output_port
  import bcd_port_pkg::*;
#(
  parameter int STROBE_CYCLES = STROBE_LOW_CYCLES
)
(
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic               data_request_input,
  input  wire logic               hold_n,
  input  wire logic               conversion_done,
  input  wire reading_s           conversion_reading,
  output logic                    convert_enable,
  output logic [DIGIT_W-1:0]      digit_out,
  output logic                    sign_out,
  output logic                    overload_out,
  output logic                    data_valid_strobe,
  output logic                    continuous_output_line,
  output logic                    irq,
  input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [ADDR_W-1:0]  s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready
);

  localparam logic [CNT_W-1:0] STROBE_LAST = CNT_W'(STROBE_CYCLES - 1);
  localparam logic [CONT_W-1:0] CONT_LOAD  = CONT_W'(CONT_HIGH_CYCLES);
  localparam int               TOP_LSB     = DIGIT_W - NIBBLE;

  port_state_s cur;
  port_state_s next_state;

  logic             req_edge;
  logic             conv_taken;
  logic             strobe_start;
  logic             do_write;
  logic [IRQ_W-1:0] irq_event;
  logic [IRQ_W-1:0] irq_clear;

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign convert_enable         = ~cur.held;
  assign digit_out              = cur.shown.digits;
  assign sign_out               = cur.shown.sign;
  assign overload_out           = cur.shown.overload;
  assign data_valid_strobe      = cur.strobe_n;
  assign continuous_output_line = cur.cont_line;
  assign irq                    = |(cur.irq_status & cur.irq_mask);
  assign s_axi_awready          = ~cur.aw_got & ~cur.bvalid;
  assign s_axi_wready           = ~cur.w_got & ~cur.bvalid;
  assign s_axi_bvalid           = cur.bvalid;
  assign s_axi_bresp            = cur.bresp;
  assign s_axi_arready          = ~cur.rvalid;
  assign s_axi_rvalid           = cur.rvalid;
  assign s_axi_rdata            = cur.rdata;
  assign s_axi_rresp            = cur.rresp;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb
  begin
    next_state = cur;

    // the request and hold pins pass two flops before any logic looks at them
    next_state.req_sync1  = data_request_input;
    next_state.req_sync2  = cur.req_sync1;
    next_state.req_prev   = cur.req_sync2;
    next_state.hold_sync1 = hold_n;
    next_state.hold_sync2 = cur.hold_sync1;
    next_state.held       = ~cur.hold_sync2;

    do_write = cur.aw_got & cur.w_got & ~cur.bvalid;

    // a level that stays high yields one edge only; software may also request
    req_edge = (cur.req_sync2 & ~cur.req_prev)
             | (do_write & (cur.aw_addr == OFS_CTRL) & cur.w_strb[0]
                & cur.w_data[CTRL_SW_REQ]);
    conv_taken   = conversion_done & ~cur.held;
    strobe_start = conv_taken & cur.pending & cur.strobe_n & cur.hold_sync2;

    // conversions announce themselves so that the line can feed the request pin
    if (conv_taken)
    begin
      next_state.cont_line = 1'b1;
      next_state.cont_cnt  = CONT_LOAD;
    end
    else if (cur.cont_cnt != '0)
    begin
      next_state.cont_cnt  = cur.cont_cnt - CONT_W'(1);
      next_state.cont_line = (cur.cont_cnt != CONT_W'(1));
    end
    else
    begin
      next_state.cont_line = 1'b0;
    end

    // held drops requests; an edge landing in the issuing cycle survives
    next_state.pending = cur.held ? 1'b0
                       : ((cur.pending & ~strobe_start) | req_edge);
    // the strobe parks high on the very edge that raises held, aborting a pulse
    if (next_state.held)
    begin
      next_state.strobe_n   = 1'b1;
      next_state.strobe_cnt = '0;
    end
    else if (strobe_start)
    begin
      // outputs load on the edge the strobe goes low; clearing ext_res also blanks the top digit at once
      next_state.strobe_n     = 1'b0;
      next_state.strobe_cnt   = '0;
      next_state.shown        = conversion_reading;
      next_state.strobe_total = cur.strobe_total + TOTAL_W'(1);
    end
    else if (!cur.strobe_n)
    begin
      next_state.strobe_cnt = cur.strobe_cnt + CNT_W'(1);
      if (cur.strobe_cnt == STROBE_LAST)
      begin
        next_state.strobe_n = 1'b1;
      end
    end

    // ---------------- axi4-lite write ----------------
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_state.aw_got  = 1'b1;
      next_state.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_state.w_got  = 1'b1;
      next_state.w_data = s_axi_wdata;
      next_state.w_strb = s_axi_wstrb;
    end
    irq_clear = '0;
    if (do_write)
    begin
      next_state.aw_got = 1'b0;
      next_state.w_got  = 1'b0;
      next_state.bvalid = 1'b1;
      next_state.bresp  = RESP_OKAY;
      case (cur.aw_addr)
        OFS_CTRL:
        begin
          if (cur.w_strb[0])
          begin
            next_state.ext_res = cur.w_data[CTRL_EXT_RES];
          end
        end
        OFS_IRQ_STATUS:
        begin
          if (cur.w_strb[0])
          begin
            irq_clear = cur.w_data[IRQ_W-1:0];
          end
        end
        OFS_IRQ_MASK:
        begin
          if (cur.w_strb[0])
          begin
            next_state.irq_mask = cur.w_data[IRQ_W-1:0];
          end
        end
        OFS_STATUS, OFS_READING, OFS_STROBES:
        begin
          next_state.bresp = RESP_OKAY;
        end
        default:
        begin
          next_state.bresp = RESP_SLVERR;
        end
      endcase
    end
    else if (cur.bvalid && s_axi_bready)
    begin
      next_state.bvalid = 1'b0;
    end

    // standard resolution leaves the top digit terminals dead
    if (!next_state.ext_res)
    begin
      next_state.shown.digits[DIGIT_W-1:TOP_LSB] = '0;
    end

    // sticky events: a new event beats a clear in the same cycle
    irq_event             = '0;
    irq_event[IRQ_CONV]   = conv_taken;
    irq_event[IRQ_STROBE] = strobe_start;
    irq_event[IRQ_REQ]    = req_edge & ~cur.held;
    irq_event[IRQ_HOLD]   = ~cur.hold_sync2 & ~cur.held;
    next_state.irq_status = (cur.irq_status & ~irq_clear) | irq_event;

    // ---------------- axi4-lite read ----------------
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_state.rvalid = 1'b1;
      next_state.rresp  = RESP_OKAY;
      next_state.rdata  = '0;
      case (s_axi_araddr)
        OFS_CTRL:       next_state.rdata[CTRL_EXT_RES] = cur.ext_res;
        OFS_STATUS:     next_state.rdata[5:0] = {cur.held, cur.pending, ~cur.strobe_n,
                                                 cur.cont_line, cur.shown.sign,
                                                 cur.shown.overload};
        OFS_IRQ_STATUS: next_state.rdata[IRQ_W-1:0] = cur.irq_status;
        OFS_IRQ_MASK:   next_state.rdata[IRQ_W-1:0] = cur.irq_mask;
        OFS_READING:    next_state.rdata[DIGIT_W+1:0] = cur.shown;
        OFS_STROBES:    next_state.rdata[TOTAL_W-1:0] = cur.strobe_total;
        default:        next_state.rresp = RESP_SLVERR;
      endcase
    end
    else if (cur.rvalid && s_axi_rready)
    begin
      next_state.rvalid = 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cur            <= '0;
      cur.hold_sync1 <= 1'b1;
      cur.hold_sync2 <= 1'b1;
      cur.strobe_n   <= 1'b1;
    end
    else
    begin
      cur <= next_state;
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  // low_run counts cycles of the current strobe pulse
  logic [CNT_W-1:0] low_run;

  always_ff @(posedge clock)
  begin
    if (rst || cur.strobe_n)
    begin
      low_run <= '0;
    end
    else
    begin
      low_run <= low_run + CNT_W'(1);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_strobe_width: assert property ($rose(data_valid_strobe) && !cur.held |->
      low_run == CNT_W'(STROBE_CYCLES))
    else $error("strobe low time differs from the set width");

  a_strobe_bound: assert property (low_run <= CNT_W'(STROBE_CYCLES))
    else $error("strobe stayed low too long");

  a_issue_load: assert property (strobe_start |=> !data_valid_strobe
      && sign_out == $past(conversion_reading.sign)
      && overload_out == $past(conversion_reading.overload))
    else $error("strobe or reading not issued on a pending conversion");

  a_held_quiet: assert property (cur.held |-> data_valid_strobe && !convert_enable)
    else $error("strobe low or converting while held");

  a_run_enable: assert property (cur.hold_sync2 |=> convert_enable)
    else $error("conversion stopped while not held");

  a_frozen_data: assert property (cur.held && $past(cur.held) |->
      $stable(digit_out) && $stable(sign_out))
    else $error("reading changed while held");

  a_top_unused: assert property (!cur.ext_res |-> digit_out[DIGIT_W-1:TOP_LSB] == '0)
    else $error("top digit driven at standard resolution");

  a_req_latch: assert property (req_edge && !cur.held |=> cur.pending)
    else $error("request edge not latched");

  a_single_edge: assert property (cur.req_sync2 && cur.req_prev && !cur.held
      && !do_write && strobe_start |=> !cur.pending)
    else $error("steady request produced another pending update");

  a_cont_pulse: assert property (conv_taken |=> continuous_output_line)
    else $error("continuous line silent after a conversion");

  a_stable_high: assert property (data_valid_strobe && $past(data_valid_strobe)
      && !$past(cur.held) |-> $stable(digit_out))
    else $error("digits changed while strobe high");

  c_strobe_pulse: cover property ($rose(data_valid_strobe) && !cur.held);
  c_hold_entry:   cover property ($rose(cur.held));
  c_axi_write:    cover property (do_write);
  c_axi_read:     cover property (s_axi_arvalid && s_axi_arready);

endmodule

// ===== src/bcd_port_pkg.sv
// constants, register map and state types for the bcd reading output port
package bcd_port_pkg;

  // ------------------------------------------------------------------
  // reading layout
  // ------------------------------------------------------------------
  localparam int DIGITS  = 5;
  localparam int NIBBLE  = 4;
  localparam int DIGIT_W = DIGITS * NIBBLE;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS   = 50;
  localparam int STROBE_LOW_NS     = 3500000;
  localparam int STROBE_LOW_CYCLES = STROBE_LOW_NS / CLOCK_PERIOD_NS;
  localparam int CONT_HIGH_NS      = 1000;
  localparam int CONT_HIGH_CYCLES  = CONT_HIGH_NS / CLOCK_PERIOD_NS;
  localparam int CNT_W             = 24;
  localparam int CONT_W            = 8;
  localparam int TOTAL_W           = 16;

  // ------------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL       = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS     = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK   = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_READING    = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STROBES    = 8'h14;

  localparam int CTRL_EXT_RES = 0;
  localparam int CTRL_SW_REQ  = 1;

  localparam int IRQ_W      = 4;
  localparam int IRQ_CONV   = 0;
  localparam int IRQ_STROBE = 1;
  localparam int IRQ_REQ    = 2;
  localparam int IRQ_HOLD   = 3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic               sign;
    logic               overload;
    logic [DIGIT_W-1:0] digits;
  } reading_s;

  typedef struct packed {
    logic               req_sync1;
    logic               req_sync2;
    logic               req_prev;
    logic               hold_sync1;
    logic               hold_sync2;
    logic               held;
    logic               pending;
    logic               strobe_n;
    logic [CNT_W-1:0]   strobe_cnt;
    logic               cont_line;
    logic [CONT_W-1:0]  cont_cnt;
    reading_s           shown;
    logic               ext_res;
    logic [IRQ_W-1:0]   irq_status;
    logic [IRQ_W-1:0]   irq_mask;
    logic [TOTAL_W-1:0] strobe_total;
    logic               aw_got;
    logic [ADDR_W-1:0]  aw_addr;
    logic               w_got;
    logic [31:0]        w_data;
    logic [3:0]         w_strb;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
  } port_state_s;

endpackage

// ===== testbench/reading_logger.sv
// peripheral model that latches each reading on the rising edge of the strobe
`timescale 1ns/100ps
module reading_logger
  import bcd_port_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic               data_valid_strobe,
  input  wire logic [DIGIT_W-1:0] digit_out,
  input  wire logic               sign_out,
  input  wire logic               overload_out,
  output reading_s                captured,
  output int                      n_cap
);
  logic strobe_prev;

  // outputs load on the same edge the strobe goes low, so only its return high is trusted
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      strobe_prev <= 1'b1;
      captured    <= '0;
      n_cap       <= 0;
    end
    else
    begin
      strobe_prev <= data_valid_strobe;
      if (data_valid_strobe && !strobe_prev)
      begin
        captured <= {sign_out, overload_out, digit_out};
        n_cap    <= n_cap + 1;
      end
    end
  end
endmodule

// ===== testbench/tb_bcd_reading_output_port.sv
// self-checking bench for the bcd reading output port
`timescale 1ns/100ps
module tb_bcd_reading_output_port;
  import bcd_port_pkg::*;
  // short strobe keeps the run brief
  localparam int SC = 20;
  logic               clock, cont_line, convert_enable, irq;
  logic               sign_out, overload_out, data_valid_strobe;
  logic               rst = 1'b1, req_drv = 1'b0, cont_mode = 1'b0, hold_n = 1'b1;
  logic               conv_done = 1'b0;
  reading_s           conv_rd = '0, cap, r;
  logic [DIGIT_W-1:0] digit_out;
  logic [ADDR_W-1:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]        s_axi_wdata = '0, s_axi_rdata;
  logic [1:0]         s_axi_bresp, s_axi_rresp;
  logic               s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic               s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int                 err_count = 0, n_checks = 0, cyc = 0, n_cap, n;
  wire logic          req = cont_mode ? cont_line : req_drv;
  wire logic [21:0]   shown = {sign_out, overload_out, digit_out};

  bcd_reading_output_port #(.STROBE_CYCLES(SC)) i_dut (
    .clock(clock), .rst(rst), .data_request_input(req), .hold_n(hold_n),
    .conversion_done(conv_done), .conversion_reading(conv_rd),
    .convert_enable(convert_enable), .digit_out(digit_out), .sign_out(sign_out),
    .overload_out(overload_out), .data_valid_strobe(data_valid_strobe),
    .continuous_output_line(cont_line), .irq(irq),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  reading_logger i_logger (
    .clock(clock), .rst(rst), .data_valid_strobe(data_valid_strobe), .digit_out(digit_out),
    .sign_out(sign_out), .overload_out(overload_out), .captured(cap), .n_cap(n_cap));

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic end_sim();
    if (err_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask

  function automatic reading_s rnd();
    reading_s rd;
    for (int i = 0; i < DIGITS; i++)
      rd.digits[i*NIBBLE +: NIBBLE] = NIBBLE'($urandom_range(9, 0));
    rd.sign     = 1'($urandom);
    rd.overload = 1'($urandom);
    return rd;
  endfunction

  // standard resolution leaves the top digit blank
  function automatic logic [21:0] expo(input reading_s rd, input logic ext);
    expo = rd;
    if (!ext)
      expo[19:16] = 4'h0;
  endfunction

  // ready is looked at on the falling edge, where it is settled for the next rise
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, da, dw, tb;
    logic [1:0] rs;
    @(posedge clock);
    da = 1'b0;
    dw = 1'b0;
    tb = 1'b0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(da && dw))
    begin
      @(negedge clock);
      ta = s_axi_awready && !da;
      tw = s_axi_wready && !dw;
      @(posedge clock);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      da = da || ta;
      dw = dw || tw;
    end
    while (!tb)
    begin
      @(negedge clock);
      tb = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge clock);
    end
    s_axi_bready <= 1'b0;
    check(rs, er);
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic t;
    logic [31:0] d;
    logic [1:0] rs;
    @(posedge clock);
    t = 1'b0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!t)
    begin
      @(negedge clock);
      t = s_axi_arready;
      @(posedge clock);
    end
    s_axi_arvalid <= 1'b0;
    t = 1'b0;
    while (!t)
    begin
      @(negedge clock);
      t  = s_axi_rvalid;
      d  = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge clock);
    end
    s_axi_rready <= 1'b0;
    check(d, ed);
    check(rs, er);
  endtask

  task automatic rq();
    @(posedge clock);
    req_drv <= 1'b1;
    repeat (4) @(posedge clock);
    req_drv <= 1'b0;
    repeat (4) @(posedge clock);
  endtask

  task automatic conv(input reading_s rd);
    @(posedge clock);
    conv_done <= 1'b1;
    conv_rd   <= rd;
    @(posedge clock);
    conv_done <= 1'b0;
  endtask

  // zero means no update was issued for the conversion just sent
  task automatic low_cycles(output int k);
    k = 0;
    @(negedge clock);
    while (data_valid_strobe !== 1'b1 && k < 200)
    begin
      k++;
      @(negedge clock);
    end
  endtask

  task automatic upd(input logic ext);
    reading_s rd;
    rd = rnd();
    rq();
    conv(rd);
    low_cycles(n);
    check(n, SC);
    @(negedge clock);
    check(shown, expo(rd, ext));
    check(cap, expo(rd, ext));
  endtask

  // ------------------------------------------------------------------
  // stimulus
  // ------------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      end_sim();
    end
  end

  initial
  begin
    void'($urandom(10));
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    check(shown, 0);
    check(data_valid_strobe, 1);
    check(convert_enable, 1);
    axr(OFS_IRQ_MASK, 0, RESP_OKAY);
    axw(OFS_IRQ_MASK, 32'h2, RESP_OKAY);
    axr(OFS_IRQ_MASK, 32'h2, RESP_OKAY);
    axr(8'h20, 0, RESP_SLVERR);
    axw(8'h24, 32'h1, RESP_SLVERR);
    repeat (4) upd(1'b0);
    axw(OFS_CTRL, 32'h1, RESP_OKAY);
    upd(1'b1);
    r = rnd();
    repeat (3) rq();
    conv(r);
    low_cycles(n);
    check(n, SC);
    conv(rnd());
    low_cycles(n);
    check(n, 0);
    check(shown, expo(r, 1'b1));
    @(posedge clock);
    req_drv <= 1'b1;
    repeat (5) @(posedge clock);
    for (int i = 0; i < 3; i++)
    begin
      conv(rnd());
      low_cycles(n);
      check(n, i ? 0 : SC);
    end
    @(posedge clock);
    req_drv   <= 1'b0;
    // let the line from the last conversion fall, so that its next rise is a clean edge
    repeat (25) @(posedge clock);
    cont_mode <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      r = rnd();
      conv(r);
      low_cycles(n);
      check(n, i ? SC : 0);
      if (i == 0) check(cont_line, 1);
      repeat (25) @(posedge clock);
    end
    cont_mode <= 1'b0;
    hold_n    <= 1'b0;
    repeat (5) @(posedge clock);
    rq();
    conv(rnd());
    low_cycles(n);
    check(n, 0);
    check(convert_enable, 0);
    check(shown, expo(r, 1'b1));
    @(posedge clock);
    hold_n <= 1'b1;
    repeat (5) @(posedge clock);
    conv(rnd());
    low_cycles(n);
    check(n, 0);
    check(convert_enable, 1);
    upd(1'b1);
    check(irq, 1);
    axw(OFS_IRQ_STATUS, 32'hf, RESP_OKAY);
    @(negedge clock);
    check(irq, 0);
    upd(1'b1);
    check(irq, 1);
    axw(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
    @(negedge clock);
    check(irq, 0);
    axr(OFS_STROBES, n_cap, RESP_OKAY);
    end_sim();
  end
endmodule
